// ===== verilog/usfd_pkg.sv
// Purpose: Constants and types of the serial flag, status and data block
// Assumes: Register index times four gives the byte address on the port
package usfd_pkg;
  // Register indices, byte address is index times four
  localparam logic [5:0] IDX_CTRL    = 6'h00;
  localparam logic [5:0] IDX_IEN_CLR = 6'h0c;
  localparam logic [5:0] IDX_IEN_SET = 6'h0d;
  localparam logic [5:0] IDX_FLAGS   = 6'h0e;
  localparam logic [5:0] IDX_STATUS  = 6'h10;
  localparam logic [5:0] IDX_DATA    = 6'h18;
  // Event flag and status bit positions
  localparam int unsigned FLG_RXS  = 3;
  localparam int unsigned FLG_RXC  = 2;
  localparam int unsigned FLG_TXC  = 1;
  localparam int unsigned FLG_DRE  = 0;
  localparam int unsigned ST_SYNC  = 15;
  localparam int unsigned ST_OVF   = 2;
  localparam int unsigned ST_FRAME_ERROR  = 1;
  localparam int unsigned ST_PARITY_ERROR  = 0;
  // Control register layout
  localparam int unsigned CTL_RXEN = 0;
  localparam int unsigned CTL_START_OF_FRAME_DETECT_ENABLE = 1;
  localparam int unsigned CTL_FRAME_FORMAT = 4;
  localparam logic [3:0]  FRAME_FORMAT_PARITY = 4'h1;
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [3:0]  IEN_RESET   = 4'h0;
  localparam logic [8:0]  DATA_RESET  = 9'h000;
  // Crossing time into the core domain
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SYNC_TIME_NS  = 30;
  localparam int unsigned SYNC_CYCLES   =
    (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // One received character with its own error state
  typedef struct packed {
    logic       ovf;
    logic       frame_error;
    logic       parity_error;
    logic [8:0] data;
  } usfd_rxchar_s;
  localparam usfd_rxchar_s RXCHAR_RESET = '{1'b0, 1'b0, 1'b0, DATA_RESET};
endpackage

// ===== verilog/usfd_top.sv
// Purpose: Flag, status and data register logic of an async serial port
// Assumes: Shift registers and line logic sit outside, on the same clock
// Notes:   Two-entry receive buffer plus one waiting character slot
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module usfd_top (
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        RX_START,
  input  wire logic        RX_DONE,
  input  wire logic [8:0]  RX_DATA,
  input  wire logic        RX_STOP_BIT,
  input  wire logic        RX_PARITY_BAD,
  input  wire logic        TX_SHIFT_READY,
  input  wire logic        TX_SHIFT_DONE,
  output logic             TX_LOAD,
  output logic      [8:0]  TX_DATA,
  output logic             RX_ENABLE,
  output logic             START_OF_FRAME_DETECT_ENABLE_OUT,
  output logic      [3:0]  FRAME_FORMAT,
  output logic             IRQ
);
  // Address decode, one aligned word per register
  // Exact match on the byte address: unaligned offsets read as zero and
  // ignore writes, so a stray access cannot alias onto a live register
  logic hit_ctrl, hit_iclr, hit_iset, hit_flags, hit_stat, hit_data;
  assign hit_ctrl  = (ADDR == {usfd_pkg::IDX_CTRL, 2'b00});
  assign hit_iclr  = (ADDR == {usfd_pkg::IDX_IEN_CLR, 2'b00});
  assign hit_iset  = (ADDR == {usfd_pkg::IDX_IEN_SET, 2'b00});
  assign hit_flags = (ADDR == {usfd_pkg::IDX_FLAGS, 2'b00});
  assign hit_stat  = (ADDR == {usfd_pkg::IDX_STATUS, 2'b00});
  assign hit_data  = (ADDR == {usfd_pkg::IDX_DATA, 2'b00});

  // Control and crossing state
  logic [7:0] ctl_r, ctl_nxt, pend_r, pend_nxt;
  logic       busy_r, busy_nxt;
  logic [7:0] scnt_r, scnt_nxt;
  logic       rxen, start_of_frame_detect_enable;
  logic [3:0] frame_format;
  // Effective settings come from the applied copy, never the pending one
  assign rxen = ctl_r[usfd_pkg::CTL_RXEN];
  assign start_of_frame_detect_enable = ctl_r[usfd_pkg::CTL_START_OF_FRAME_DETECT_ENABLE];
  assign frame_format = ctl_r[usfd_pkg::CTL_FRAME_FORMAT +: 4];

  // Control writes land in a pending copy; the core sees them only after
  // the crossing count, so a second write restarts the crossing
  always_comb begin
    ctl_nxt  = ctl_r;
    pend_nxt = pend_r;
    busy_nxt = busy_r;
    scnt_nxt = scnt_r;
    if (WR && hit_ctrl) begin
      pend_nxt = WDATA[7:0];
      busy_nxt = 1'b1;
      scnt_nxt = 8'(usfd_pkg::SYNC_CYCLES);
    end else if (busy_r) begin
      if (scnt_r <= 8'h01) begin
        ctl_nxt  = pend_r;
        busy_nxt = 1'b0;
        scnt_nxt = 8'h00;
      end else begin
        scnt_nxt = scnt_r - 8'h01;
      end
    end
  end

  // Pending copy and counter register together; busy tracks the count,
  // so software sees the crossing for exactly as long as it lasts
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ctl_r  <= usfd_pkg::CTL_RESET;
      pend_r <= usfd_pkg::CTL_RESET;
      busy_r <= 1'b0;
      scnt_r <= 8'h00;
    end else begin
      ctl_r  <= ctl_nxt;
      pend_r <= pend_nxt;
      busy_r <= busy_nxt;
      scnt_r <= scnt_nxt;
    end
  end

  // Receive buffer: two entries, plus one character waiting in the shifter
  // cnt_r counts buffered entries and rp_r points at the oldest; the waiting
  // slot stands for a character still parked in the receive shifter
  usfd_pkg::usfd_rxchar_s buf_r [2];
  usfd_pkg::usfd_rxchar_s buf_nxt [2];
  usfd_pkg::usfd_rxchar_s hold_r, hold_nxt, newc, head;
  logic       hv_r, hv_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       pop;
  // Read data always comes from the oldest entry; status error bits do while the buffer is not empty
  assign head = buf_r[rp_r];
  // A data read on an empty buffer returns stale data and pops nothing
  assign pop  = RD && hit_data && (cnt_r != 2'd0);

  // Each character carries its own error bits into the buffer
  always_comb begin
    newc      = usfd_pkg::RXCHAR_RESET;
    newc.data = RX_DATA;
    newc.frame_error = ~RX_STOP_BIT;
    newc.parity_error = RX_PARITY_BAD && (frame_format == usfd_pkg::FRAME_FORMAT_PARITY);
  end

  // Pop first, refill from the waiting slot, then take a new character
  always_comb begin
    buf_nxt  = buf_r;
    hold_nxt = hold_r;
    hv_nxt   = hv_r;
    rp_nxt   = rp_r;
    cnt_nxt  = cnt_r;
    if (pop) begin
      rp_nxt  = ~rp_r;
      cnt_nxt = cnt_r - 2'd1;
    end
    // Write one to an error bit clears it on the character at the head
    if (WR && hit_stat) begin
      buf_nxt[rp_r].ovf  = buf_r[rp_r].ovf  & ~WDATA[usfd_pkg::ST_OVF];
      buf_nxt[rp_r].frame_error = buf_r[rp_r].frame_error & ~WDATA[usfd_pkg::ST_FRAME_ERROR];
      buf_nxt[rp_r].parity_error = buf_r[rp_r].parity_error & ~WDATA[usfd_pkg::ST_PARITY_ERROR];
    end
    // A freed slot is refilled from the waiting character first, so the
    // arrival order holds when a read and a new character meet
    if (hv_nxt && cnt_nxt != 2'd2) begin
      buf_nxt[rp_nxt ^ cnt_nxt[0]] = hold_r;
      cnt_nxt = cnt_nxt + 2'd1;
      hv_nxt  = 1'b0;
    end
    // With both entries and the waiting slot taken, a new character is lost
    if (RX_DONE && rxen) begin
      if (!hv_nxt && cnt_nxt != 2'd2) begin
        buf_nxt[rp_nxt ^ cnt_nxt[0]] = newc;
        cnt_nxt = cnt_nxt + 2'd1;
      end else if (!hv_nxt) begin
        hold_nxt = newc;
        hv_nxt   = 1'b1;
      end
    end
    // Overflow marks the waiting character, the one read after both buffered entries
    if (RX_START && rxen && cnt_r == 2'd2 && hv_r) begin
      hold_nxt.ovf = 1'b1;
    end
    // Disabling the receiver empties the buffer and the waiting slot; error bits stay in the entries
    // The flush follows the applied enable, so it lands after the crossing
    if (!rxen) begin
      cnt_nxt = 2'd0;
      hv_nxt  = 1'b0;
      rp_nxt  = 1'b0;
    end
  end

  // Buffer registers; stale error bits left after a flush are harmless
  // because status shows none while the count is zero; a data read still returns stale data
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      buf_r[0] <= usfd_pkg::RXCHAR_RESET;
      buf_r[1] <= usfd_pkg::RXCHAR_RESET;
      hold_r   <= usfd_pkg::RXCHAR_RESET;
      hv_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'd0;
    end else begin
      buf_r  <= buf_nxt;
      hold_r <= hold_nxt;
      hv_r   <= hv_nxt;
      rp_r   <= rp_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  // Transmit holding register and flags
  // txd_r holds what software wrote, txo_r what the shifter was given
  logic [8:0] txd_r, txd_nxt, txo_r, txo_nxt;
  logic       full_r, full_nxt, dre_r, dre_nxt, txc_r, txc_nxt;
  logic       load_r, load_nxt, data_wr;
  assign data_wr = WR && hit_data;

  // Load is guarded by the previous load so a slow ready cannot double it
  always_comb begin
    txd_nxt  = txd_r;
    txo_nxt  = txo_r;
    full_nxt = full_r;
    load_nxt = 1'b0;
    txc_nxt  = txc_r;
    if (full_r && TX_SHIFT_READY && !load_r) begin
      load_nxt = 1'b1;
      txo_nxt  = txd_r;
      full_nxt = 1'b0;
    end
    // A write in the load cycle refills the holding register at once
    if (data_wr) begin
      txd_nxt  = WDATA[8:0];
      full_nxt = 1'b1;
    end
    // Transmit complete drops on a write of one or on new data
    if ((WR && hit_flags && WDATA[usfd_pkg::FLG_TXC]) || data_wr) begin
      txc_nxt = 1'b0;
    end
    // Set wins over a write-one clear in the same cycle, but not over new data
    if (TX_SHIFT_DONE && !full_r && !data_wr) begin
      txc_nxt = 1'b1;
    end
    dre_nxt = ~full_nxt;
  end

  // Transmit registers; the empty flag comes up one cycle after reset ends
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      txd_r  <= usfd_pkg::DATA_RESET;
      txo_r  <= usfd_pkg::DATA_RESET;
      full_r <= 1'b0;
      dre_r  <= 1'b0;
      txc_r  <= 1'b0;
      load_r <= 1'b0;
    end else begin
      txd_r  <= txd_nxt;
      txo_r  <= txo_nxt;
      full_r <= full_nxt;
      dre_r  <= dre_nxt;
      txc_r  <= txc_nxt;
      load_r <= load_nxt;
    end
  end

  // Start flag, enables, interrupt and read data
  logic        rxs_r, rxs_nxt, irq_r, irq_nxt;
  logic [3:0]  ien_r, ien_nxt, flags;
  logic [31:0] rd_r, rd_nxt;
  logic [15:0] status;
  assign flags = {rxs_r, (cnt_r != 2'd0), txc_r, dre_r};

  // Errors shown are those of the next character a data read returns
  // An empty buffer reports no errors, whatever stale entries hold
  always_comb begin
    status = 16'h0000;
    status[usfd_pkg::ST_SYNC] = busy_r;
    if (cnt_r != 2'd0) begin
      status[usfd_pkg::ST_OVF]  = head.ovf;
      status[usfd_pkg::ST_FRAME_ERROR] = head.frame_error;
      status[usfd_pkg::ST_PARITY_ERROR] = head.parity_error;
    end
  end

  // Start flag, enable set and clear, interrupt and read multiplexer
  // A start seen in the cycle of a clearing write keeps the flag set
  always_comb begin
    rxs_nxt = rxs_r;
    if (WR && hit_flags && WDATA[usfd_pkg::FLG_RXS]) begin
      rxs_nxt = 1'b0;
    end
    if (RX_START && start_of_frame_detect_enable) begin
      rxs_nxt = 1'b1;
    end
    ien_nxt = ien_r;
    if (WR && hit_iset) begin
      ien_nxt = ien_r | WDATA[3:0];
    end
    if (WR && hit_iclr) begin
      ien_nxt = ien_r & ~WDATA[3:0];
    end
    // Interrupt is registered, so it lags the flags by one cycle
    irq_nxt = |(flags & ien_r);
    // Read data is zero outside the answer cycle, unmapped reads included
    rd_nxt  = 32'h0000_0000;
    if (RD) begin
      if (hit_ctrl) rd_nxt = {24'h000000, pend_r};
      else if (hit_iclr || hit_iset) rd_nxt = {28'h0000000, ien_r};
      else if (hit_flags) rd_nxt = {28'h0000000, flags};
      else if (hit_stat) rd_nxt = {16'h0000, status};
      else if (hit_data) rd_nxt = {23'h000000, head.data};
    end
  end

  // Registered read data and interrupt keep both outputs free of glitches
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      rxs_r <= 1'b0;
      ien_r <= usfd_pkg::IEN_RESET;
      irq_r <= 1'b0;
      rd_r  <= 32'h0000_0000;
    end else begin
      rxs_r <= rxs_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA        = rd_r;
  assign TX_LOAD      = load_r;
  assign TX_DATA      = txo_r;
  assign RX_ENABLE    = rxen;
  assign START_OF_FRAME_DETECT_ENABLE_OUT     = start_of_frame_detect_enable;
  assign FRAME_FORMAT = frame_format;
  assign IRQ          = irq_r;
endmodule
`default_nettype wire

// ===== verification/usfd_properties.sv
// Purpose: Port timing checks for the flag, status and data block
// Assumes: Control crossing of three cycles, byte addresses as mapped
// Notes:   Attached by bind below the module
`timescale 1ns/10ps
`default_nettype none
module usfd_properties (
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        TX_SHIFT_READY,
  input wire logic        TX_LOAD,
  input wire logic [8:0]  TX_DATA,
  input wire logic        RX_ENABLE,
  input wire logic        START_OF_FRAME_DETECT_ENABLE_OUT,
  input wire logic [3:0]  FRAME_FORMAT,
  input wire logic        IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  logic [7:0] ctl_w_r;
  logic [8:0] tx_w_r;
  wire  [5:0] ctl_out = {FRAME_FORMAT, START_OF_FRAME_DETECT_ENABLE_OUT, RX_ENABLE};
  wire  [5:0] ctl_want = {ctl_w_r[7:4], ctl_w_r[1:0]};
  // Last control and data words; outputs must follow them some cycles later
  always_ff @(posedge CLOCK) begin
    if (WR && ADDR == 8'h00) ctl_w_r <= WDATA[7:0];
    if (WR && ADDR == 8'h60) tx_w_r <= WDATA[8:0];
  end
  sequence ctl_wr; WR && ADDR == 8'h00; endsequence
  sequence ctl_quiet; (!(WR && ADDR == 8'h00)) [*3]; endsequence
  sequence tx_wr; WR && ADDR == 8'h60 && !TX_LOAD; endsequence
  sequence clr_all; WR && ADDR == 8'h30 && WDATA[3:0] == 4'hf; endsequence
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside answer cycle");
  a_rdata_narrow: assert property (RD && ADDR == 8'h60 |=> RDATA[31:9] == 23'h0)
    else $error("data read has upper bits set");
  a_ctrl_hold: assert property (ctl_wr |=> $stable(ctl_out) [*3])
    else $error("control applied before crossing ends");
  a_ctrl_apply: assert property (ctl_wr ##1 ctl_quiet |=> ctl_out == ctl_want)
    else $error("control not applied after crossing");
  a_irq_clear: assert property (clr_all ##1 !(WR && ADDR == 8'h34) |=> !IRQ)
    else $error("interrupt up with all enables cleared");
  a_load_pulse: assert property (TX_LOAD |=> !TX_LOAD)
    else $error("load pulse too long");
  a_load_ready: assert property (TX_LOAD |-> $past(TX_SHIFT_READY))
    else $error("load while shifter busy");
  a_load_data: assert property (tx_wr ##1 (TX_SHIFT_READY && !TX_LOAD && !WR)
    |=> TX_LOAD && TX_DATA == tx_w_r) else $error("written character not loaded");
  a_txdata_hold: assert property (!TX_LOAD |-> $stable(TX_DATA))
    else $error("transmit data moved without load");
endmodule
bind usfd_top usfd_properties u_props (
  .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .TX_SHIFT_READY(TX_SHIFT_READY), .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA),
  .RX_ENABLE(RX_ENABLE), .START_OF_FRAME_DETECT_ENABLE_OUT(START_OF_FRAME_DETECT_ENABLE_OUT), .FRAME_FORMAT(FRAME_FORMAT), .IRQ(IRQ));
`default_nettype wire

// ===== verification/usfd_line_model.sv
// Purpose: Line side of the port: receive and transmit shifters
// Assumes: Driven from the bench by task calls
// Notes:   Released receive lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module usfd_line_model (
  input  wire logic       clk,
  input  wire logic       tx_load,
  input  wire logic       hold,
  output logic            rx_start,
  output logic            rx_done,
  output logic      [8:0] rx_data,
  output logic            rx_stop,
  output logic            rx_pbad,
  output logic            tx_ready,
  output logic            tx_done
);
  logic [3:0] busy_r = 4'h0;
  initial {rx_start, rx_done, rx_data, rx_stop, rx_pbad, tx_done} = '0;
  assign tx_ready = !hold && busy_r == 4'h0;
  // Shifter stays busy a few cycles per frame, then reports it gone
  always @(posedge clk) begin
    tx_done <= busy_r == 4'h1;
    busy_r  <= tx_load ? 4'h5 : (busy_r == 4'h0 ? 4'h0 : busy_r - 4'h1);
  end
  // Start bit, then (when whole) the finished character with its checks
  task automatic send(input logic [8:0] d, input logic stop, input logic pbad,
                      input logic whole);
    @(posedge clk);
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    rx_done  <= whole;
    rx_data  <= d;
    rx_stop  <= stop;
    rx_pbad  <= pbad;
    @(posedge clk);
    rx_done  <= 1'b0;
    {rx_data, rx_stop, rx_pbad} <= ~{d, stop, pbad};
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the flag, status and data block
// Assumes: Line model stands in for the shifters
// Notes:   Random characters and error bits from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, hold = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [8:0]  d [3];
  logic [1:0]  e [3];
  int          mismatches = 0, num_checks = 0;
  wire  [31:0] rdata;
  wire  [8:0]  rx_data, tx_data;
  wire         rx_start, rx_done, rx_stop, rx_pbad, tx_ready, tx_done, tx_load, irq;
  // Bus clock
  always #5 clk = ~clk;
  usfd_top uut (
    .CLOCK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .RX_START(rx_start), .RX_DONE(rx_done), .RX_DATA(rx_data), .RX_STOP_BIT(rx_stop),
    .RX_PARITY_BAD(rx_pbad), .TX_SHIFT_READY(tx_ready), .TX_SHIFT_DONE(tx_done),
    .TX_LOAD(tx_load), .TX_DATA(tx_data), .RX_ENABLE(), .START_OF_FRAME_DETECT_ENABLE_OUT(), .FRAME_FORMAT(),
    .IRQ(irq));
  usfd_line_model line (
    .clk(clk), .tx_load(tx_load), .hold(hold), .rx_start(rx_start), .rx_done(rx_done),
    .rx_data(rx_data), .rx_stop(rx_stop), .rx_pbad(rx_pbad), .tx_ready(tx_ready),
    .tx_done(tx_done));
  // Status expected for a character: overflow, frame and parity bits
  function automatic logic [31:0] exp_st(input logic [1:0] er, input logic ovf, input logic par);
    return {29'h0, ovf, ~er[1], er[0] & par};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, exp, rdata);
  endtask
  // Bounded wait for a load or for the frame to leave the shifter
  task automatic wait_for(input logic on_done);
    int n;
    n = 0;
    while ((on_done ? tx_done : tx_load) !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 50) begin
      mismatches++;
      close_out();
    end
  endtask
  task automatic set_ctl(input logic [7:0] v);
    wr_reg(8'h00, {24'h0, v});
    rd_chk(8'h40, 32'h8000, "busy");
    rd_chk(8'h00, {24'h0, v}, "ctrl");
    repeat (2) @(posedge clk);
    rd_chk(8'h40, 32'h0, "idle");
  endtask
  // Holding the shifter busy exposes the full state before the load
  task automatic tx(input logic [8:0] v);
    hold <= 1'b1;
    wr_reg(8'h60, {23'h0, v});
    rd_chk(8'h38, 32'h0, "flags full");
    hold <= 1'b0;
    wait_for(1'b0);
    chk("tx data", {23'h0, v}, {23'h0, tx_data});
    wait_for(1'b1);
    rd_chk(8'h38, 32'h3, "flags sent");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'hb2b0));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(8'h38, 32'h1, "flags");
    rd_chk(8'h04, 32'h0, "unmapped");
    wr_reg(8'h34, 32'h1);
    wr_reg(8'h30, 32'h0);
    @(posedge clk);
    #1 chk("irq on", 32'h1, {31'h0, irq});
    rd_chk(8'h30, 32'h1, "enable view");
    rd_chk(8'h34, 32'h1, "enable set view");
    wr_reg(8'h30, 32'hf);
    @(posedge clk);
    #1 chk("irq off", 32'h0, {31'h0, irq});
    $display("test registers done");
    // Parity on with start detect, then both off; third character overflows
    for (int f = 1; f >= 0; f--) begin
      set_ctl(f[0] ? 8'h13 : 8'h01);
      for (int i = 0; i < 3; i++) begin
        d[i] = 9'($urandom);
        e[i] = 2'($urandom);
        line.send(d[i], e[i][1], e[i][0], 1'b1);
      end
      line.send(9'h0, 1'b1, 1'b0, 1'b0);
      wr_reg(8'h38, 32'h4);
      for (int i = 0; i < 3; i++) begin
        rd_chk(8'h38, {28'h0, f[0], 3'h5}, "flags rx");
        rd_chk(8'h40, exp_st(e[i], i == 2, f[0]), "status");
        if (i == 2) begin
          wr_reg(8'h40, 32'h0);
          rd_chk(8'h40, exp_st(e[i], 1'b1, f[0]), "status kept");
          wr_reg(8'h40, 32'h7);
          rd_chk(8'h40, 32'h0, "status clr");
        end
        rd_chk(8'h60, {23'h0, d[i]}, "data");
      end
      wr_reg(8'h38, 32'h8);
      rd_chk(8'h38, 32'h1, "rxs clr");
    end
    $display("test receive done");
    line.send(d[0], 1'b0, 1'b1, 1'b1);
    rd_chk(8'h40, 32'h2, "frame error");
    wr_reg(8'h00, 32'h0);
    repeat (5) @(posedge clk);
    rd_chk(8'h38, 32'h1, "flags off");
    rd_chk(8'h40, 32'h0, "errors off");
    $display("test disable done");
    tx(d[1]);
    tx(d[2]);
    wr_reg(8'h38, 32'h2);
    rd_chk(8'h38, 32'h1, "txc clr");
    wr_reg(8'h60, {23'h0, d[0]});
    wait_for(1'b0);
    chk("tx prompt", {23'h0, d[0]}, {23'h0, tx_data});
    $display("test transmit done");
    close_out();
  end
endmodule
`default_nettype wire
